// ---- hdl/timer_defines.svh ----
// Summary of operation
// - Two separate 8-bit up-counters each have their own period register and overflow flag.
// - An 8-bit timer counts the internal clock divided by four, or shared-pin falling edges.
// - With the cascade bit (bit 3) set the two 8-bit timers count as one 16-bit timer.
// - Control bit 2 makes the wide timer count falling edges of its own pin, else internal.
// - Control bit 1 makes the second 8-bit timer count shared-pin falling edges, else internal.
// - Control bit 0 makes the first 8-bit timer count shared-pin falling edges, else internal.
// - Bits 7-6 pick capture two's event: fall, rise, every 4th rise, every 16th rise.
// - Bits 5-4 pick capture one's event with the same four encodings.
// - The wide timer is a 16-bit counter read and written as a high and a low byte.
// - One 16-bit pair is the wide timer's period or capture one's result, set by configuration.
// - A second 16-bit pair holds only the values caught by capture two.
// - Both captures latch the wide timer's count when their selected event occurs.
// - The two 8-bit timer counts are the time base handed to the pulse-width outputs.
// - All eight control bits are read/write and clear to zero at reset.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ****************************************
// Register indices, byte address is 4x
// ****************************************
`define TC_IDX_T1 6'h10
`define TC_IDX_T2 6'h11
`define TC_IDX_PER1 6'h12
`define TC_IDX_PER2 6'h13
`define TC_IDX_WL 6'h14
`define TC_IDX_WH 6'h15
`define TC_IDX_CTRL 6'h16
`define TC_IDX_WPL 6'h17
`define TC_IDX_WPH 6'h18
`define TC_IDX_C2L 6'h19
`define TC_IDX_C2H 6'h1A
`define TC_IDX_ST 6'h1B
`define TC_IDX_MASK 6'h1C
`define TC_IDX_AUX 6'h1D

// ****************************************
// Fields and reset values
// ****************************************
`define TC_BIT_CS1 0
`define TC_BIT_CS2 1
`define TC_BIT_CS3 2
`define TC_BIT_CASC 3
`define TC_FLD_CAP1 5:4
`define TC_FLD_CAP2 7:6
`define TC_CTRL_RST 8'h00
`define TC_AUX_CAP1EN 0
`define TC_ST_T1 0
`define TC_ST_T2 1
`define TC_ST_W 2
`define TC_ST_C1 3
`define TC_ST_C2 4
`define TC_RESP_OKAY 2'h0
`define TC_RESP_SLVERR 2'h2

// ****************************************
// Timing
// ****************************************
`define TC_FOSC_DIV 4
`define TC_PRE_RISE4 4
`define TC_PRE_RISE16 16

`endif

// ---- hdl/timer_pkg.sv ----
package timer_pkg;

    // Order gives the control field encoding 0..3
    typedef enum logic [1:0] {
        CAP_FALL,
        CAP_RISE,
        CAP_RISE4,
        CAP_RISE16
    } cap_mode_type;

endpackage

// ---- hdl/cap_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module cap_channel #(
    parameter int TB_W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic pin,
    input wire timer_pkg::cap_mode_type mode,
    input wire logic [TB_W-1:0] time_base,
    output logic [TB_W-1:0] value,
    output logic hit
);
    import timer_pkg::*;

    if (TB_W < 1) begin : g_chk
        $error("cap_channel: TB_W must be positive");
    end

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic [3:0] pre_r;
    cap_mode_type mode_r;
    logic fall;
    logic rise;
    logic ev;

    // ****************************************
    // Edge qualification
    // ****************************************
    assign fall = s3_r & ~s2_r;
    assign rise = ~s3_r & s2_r;
    assign ev = (mode == CAP_FALL) ? fall :
                (mode == CAP_RISE) ? rise :
                (mode == CAP_RISE4) ? (rise & (pre_r[1:0] == 2'(`TC_PRE_RISE4 - 1))) :
                (rise & (pre_r == 4'(`TC_PRE_RISE16 - 1)));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else if (ce) begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Prescaler restarts on a mode change so the first count is whole
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pre_r <= 4'h0;
            mode_r <= CAP_FALL;
        end else if (ce) begin
            mode_r <= mode;
            if (mode_r != mode) begin
                pre_r <= 4'h0;
            end else if (rise) begin
                pre_r <= pre_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            value <= '0;
            hit <= 1'b0;
        end else if (ce) begin
            hit <= ev;
            if (ev) begin
                value <= time_base;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_cap_latch;
        @(posedge clk) disable iff (!rst_b) ce && ev |=> hit && value == $past(time_base);
    endproperty
    a_cap_latch: assert property (p_cap_latch) else $error("capture value wrong");

    property p_cap_fall;
        @(posedge clk) disable iff (!rst_b) ce && mode == CAP_FALL && mode_r == mode
            && s3_r && !s2_r |=> hit;
    endproperty
    a_cap_fall: assert property (p_cap_fall) else $error("falling edge missed");

    property p_cap_rise4;
        @(posedge clk) disable iff (!rst_b) ce && mode == CAP_RISE4 && rise
            && pre_r[1:0] != 2'h3 |=> !hit;
    endproperty
    a_cap_rise4: assert property (p_cap_rise4) else $error("early prescaled capture");
endmodule
`default_nettype wire

// ---- hdl/timer_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module timer_capture #(
    parameter int ADDR_W = 8
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic SHARED_CLK_PIN,
    input wire logic WIDE_CLK_PIN,
    input wire logic CAP_ONE_PIN,
    input wire logic CAP_TWO_PIN,
    output logic IRQ,
    output logic [7:0] FIRST_COUNT,
    output logic [7:0] SECOND_COUNT
);
    import timer_pkg::*;

    if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
        $error("timer_capture: ADDR_W must be 8..32");
    end

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = ((a >> 8) == '0) && (a[7:2] >= `TC_IDX_T1) && (a[7:2] <= `TC_IDX_AUX);
    endfunction

    function automatic logic [7:0] step8(input logic [7:0] c, input logic [7:0] p);
        step8 = (c == p) ? 8'h00 : c + 8'h01;
    endfunction

    function automatic logic [15:0] step16(input logic [15:0] c, input logic [15:0] p);
        step16 = (c == p) ? 16'h0000 : c + 16'h0001;
    endfunction

    // ****************************************
    // Register bus slave
    // ****************************************
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_lane_r;
    logic do_write;
    logic wen;
    logic [5:0] w_idx;
    logic aw_held_nxt;
    logic w_held_nxt;
    logic rvalid_nxt;
    logic [7:0] rd_val;

    assign do_write = aw_held_r & w_held_r & ~BVALID;
    assign wen = do_write & w_lane_r & is_mapped(aw_addr_r);
    assign w_idx = aw_addr_r[7:2];
    assign aw_held_nxt = (aw_held_r | (AWVALID & AWREADY)) & ~do_write;
    assign w_held_nxt = (w_held_r | (WVALID & WREADY)) & ~do_write;
    assign rvalid_nxt = (ARVALID & ARREADY) | (RVALID & ~RREADY);

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= 8'h00;
            w_lane_r <= 1'b0;
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= `TC_RESP_OKAY;
        end else if (CE) begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            AWREADY <= ~aw_held_nxt;
            WREADY <= ~w_held_nxt;
            if (AWVALID && AWREADY) begin
                aw_addr_r <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_data_r <= WDATA[7:0];
                w_lane_r <= WSTRB[0];
            end
            if (do_write) begin
                BVALID <= 1'b1;
                BRESP <= is_mapped(aw_addr_r) ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
            end else if (BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= `TC_RESP_OKAY;
        end else if (CE) begin
            RVALID <= rvalid_nxt;
            ARREADY <= ~rvalid_nxt;
            if (ARVALID && ARREADY) begin
                RDATA <= {24'h000000, rd_val};
                RRESP <= is_mapped(ARADDR) ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
            end
        end
    end

    // ****************************************
    // Registers and timers
    // ****************************************
    logic [7:0] t1_r;
    logic [7:0] t2_r;
    logic [7:0] per1_r;
    logic [7:0] per2_r;
    logic [15:0] w_r;
    logic [15:0] wp_r;
    logic [7:0] ctrl_r;
    logic aux_r;
    logic [4:0] st_r;
    logic [4:0] mask_r;
    logic [1:0] div_r;
    logic sh1_r, sh2_r, sh3_r;
    logic wd1_r, wd2_r, wd3_r;
    logic tick, sh_fall, wd_fall;
    logic cs1, cs2, cs3, casc, cap1_en;
    logic inc1, inc2, inc3;
    logic ov1, ov2, ov3;
    logic [15:0] pair;
    logic [15:0] pair_nxt;
    logic [15:0] w_period;
    logic [15:0] cap1_val, cap2_val;
    logic cap1_hit, cap2_hit;
    logic [4:0] ev;
    logic [4:0] st_nxt;
    logic wr_t1, wr_t2, wr_wl, wr_wh, wr_wpl, wr_wph;

    assign cs1 = ctrl_r[`TC_BIT_CS1];
    assign cs2 = ctrl_r[`TC_BIT_CS2];
    assign cs3 = ctrl_r[`TC_BIT_CS3];
    assign casc = ctrl_r[`TC_BIT_CASC];
    assign cap1_en = aux_r;
    assign wr_t1 = wen & (w_idx == `TC_IDX_T1);
    assign wr_t2 = wen & (w_idx == `TC_IDX_T2);
    assign wr_wl = wen & (w_idx == `TC_IDX_WL);
    assign wr_wh = wen & (w_idx == `TC_IDX_WH);
    assign wr_wpl = wen & (w_idx == `TC_IDX_WPL);
    assign wr_wph = wen & (w_idx == `TC_IDX_WPH);

    // Internal count rate is the core clock divided by four
    assign tick = div_r == 2'(`TC_FOSC_DIV - 1);
    assign sh_fall = sh3_r & ~sh2_r;
    assign wd_fall = wd3_r & ~wd2_r;
    assign inc1 = cs1 ? sh_fall : tick;
    assign inc2 = cs2 ? sh_fall : tick;
    assign inc3 = cs3 ? wd_fall : tick;
    assign pair = {t2_r, t1_r};
    assign pair_nxt = step16(pair, {per2_r, per1_r});
    // Free-running when the pair is busy holding capture results
    assign w_period = cap1_en ? 16'hFFFF : wp_r;
    assign ov1 = inc1 & (casc ? (pair == {per2_r, per1_r}) : (t1_r == per1_r));
    assign ov2 = ~casc & inc2 & (t2_r == per2_r);
    assign ov3 = inc3 & (w_r == w_period);
    assign ev = {cap2_hit, cap1_hit & cap1_en, ov3, ov2, ov1};
    // A flag raised in the clearing cycle survives
    assign st_nxt = (st_r & ~((wen && w_idx == `TC_IDX_ST) ? w_data_r[4:0] : 5'h00)) | ev;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            div_r <= 2'h0;
            {sh1_r, sh2_r, sh3_r} <= 3'h0;
            {wd1_r, wd2_r, wd3_r} <= 3'h0;
        end else if (CE) begin
            div_r <= tick ? 2'h0 : div_r + 2'h1;
            {sh1_r, sh2_r, sh3_r} <= {SHARED_CLK_PIN, sh1_r, sh2_r};
            {wd1_r, wd2_r, wd3_r} <= {WIDE_CLK_PIN, wd1_r, wd2_r};
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            t1_r <= 8'h00;
            t2_r <= 8'h00;
        end else if (CE) begin
            if (wr_t1) begin
                t1_r <= w_data_r;
            end else if (inc1) begin
                t1_r <= casc ? pair_nxt[7:0] : step8(t1_r, per1_r);
            end
            if (wr_t2) begin
                t2_r <= w_data_r;
            end else if (casc ? inc1 : inc2) begin
                t2_r <= casc ? pair_nxt[15:8] : step8(t2_r, per2_r);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            w_r <= 16'h0000;
        end else if (CE) begin
            if (wr_wl) begin
                w_r[7:0] <= w_data_r;
            end else if (wr_wh) begin
                w_r[15:8] <= w_data_r;
            end else if (inc3) begin
                w_r <= step16(w_r, w_period);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            per1_r <= 8'h00;
            per2_r <= 8'h00;
            wp_r <= 16'h0000;
            ctrl_r <= `TC_CTRL_RST;
            aux_r <= 1'b0;
            mask_r <= 5'h00;
            st_r <= 5'h00;
            IRQ <= 1'b0;
        end else if (CE) begin
            if (wen && w_idx == `TC_IDX_PER1) per1_r <= w_data_r;
            if (wen && w_idx == `TC_IDX_PER2) per2_r <= w_data_r;
            if (wen && w_idx == `TC_IDX_CTRL) ctrl_r <= w_data_r;
            if (wen && w_idx == `TC_IDX_AUX) aux_r <= w_data_r[`TC_AUX_CAP1EN];
            if (wen && w_idx == `TC_IDX_MASK) mask_r <= w_data_r[4:0];
            if (cap1_en && cap1_hit) begin
                wp_r <= cap1_val;
            end else if (wr_wpl) begin
                wp_r[7:0] <= w_data_r;
            end else if (wr_wph) begin
                wp_r[15:8] <= w_data_r;
            end
            st_r <= st_nxt;
            IRQ <= |(st_r & mask_r);
        end
    end

    // Counts leave straight from the timer flops for the pulse-width stage
    assign FIRST_COUNT = t1_r;
    assign SECOND_COUNT = t2_r;

    // ****************************************
    // Capture channels
    // ****************************************
    cap_channel #(.TB_W(16)) u_cap_one (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .pin(CAP_ONE_PIN),
        .mode(cap_mode_type'(ctrl_r[`TC_FLD_CAP1])),
        .time_base(w_r),
        .value(cap1_val),
        .hit(cap1_hit)
    );

    cap_channel #(.TB_W(16)) u_cap_two (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .pin(CAP_TWO_PIN),
        .mode(cap_mode_type'(ctrl_r[`TC_FLD_CAP2])),
        .time_base(w_r),
        .value(cap2_val),
        .hit(cap2_hit)
    );

    // ****************************************
    // Read decode
    // ****************************************
    logic [5:0] r_idx;
    assign r_idx = ARADDR[7:2];

    always_comb begin
        rd_val = 8'h00;
        if (!is_mapped(ARADDR)) rd_val = 8'h00;
        else if (r_idx == `TC_IDX_T1) rd_val = t1_r;
        else if (r_idx == `TC_IDX_T2) rd_val = t2_r;
        else if (r_idx == `TC_IDX_PER1) rd_val = per1_r;
        else if (r_idx == `TC_IDX_PER2) rd_val = per2_r;
        else if (r_idx == `TC_IDX_WL) rd_val = w_r[7:0];
        else if (r_idx == `TC_IDX_WH) rd_val = w_r[15:8];
        else if (r_idx == `TC_IDX_CTRL) rd_val = ctrl_r;
        else if (r_idx == `TC_IDX_WPL) rd_val = wp_r[7:0];
        else if (r_idx == `TC_IDX_WPH) rd_val = wp_r[15:8];
        else if (r_idx == `TC_IDX_C2L) rd_val = cap2_val[7:0];
        else if (r_idx == `TC_IDX_C2H) rd_val = cap2_val[15:8];
        else if (r_idx == `TC_IDX_ST) rd_val = {3'h0, st_r};
        else if (r_idx == `TC_IDX_MASK) rd_val = {3'h0, mask_r};
        else rd_val = {7'h00, aux_r};
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence s_t1_wrap;
        CE && !casc && inc1 && t1_r == per1_r && !wr_t1;
    endsequence

    property p_t1_wrap;
        s_t1_wrap |=> t1_r == 8'h00 && st_r[`TC_ST_T1];
    endproperty
    a_t1_wrap: assert property (p_t1_wrap) else $error("timer one wrap wrong");

    property p_t1_int;
        CE && !cs1 && !casc && !wr_t1 && t1_r != per1_r
            ##1 (CE && !cs1 && !casc && !wr_t1) [*3]
            |=> t1_r != $past(t1_r, 4);
    endproperty
    a_t1_int: assert property (p_t1_int) else $error("internal rate stalled");

    property p_casc;
        CE && casc && inc1 && !wr_t1 && !wr_t2 && pair != {per2_r, per1_r}
            |=> {t2_r, t1_r} == $past(pair) + 16'h0001;
    endproperty
    a_casc: assert property (p_casc) else $error("cascade carry wrong");

    property p_t2_ext;
        CE && !casc && cs2 && !sh_fall && !wr_t2 |=> $stable(t2_r);
    endproperty
    a_t2_ext: assert property (p_t2_ext) else $error("timer two moved without edge");

    property p_t1_ext;
        CE && !casc && cs1 && sh_fall && !wr_t1 |=> t1_r != $past(t1_r) || $past(t1_r) == 8'h00;
    endproperty
    a_t1_ext: assert property (p_t1_ext) else $error("timer one edge missed");

    property p_wide_ext;
        CE && cs3 && !wd_fall && !wr_wl && !wr_wh |=> $stable(w_r);
    endproperty
    a_wide_ext: assert property (p_wide_ext) else $error("wide timer moved without edge");

    property p_ctrl_wr;
        wen && w_idx == `TC_IDX_CTRL && CE |=> ctrl_r == $past(w_data_r);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

    property p_cap1_pair;
        CE && cap1_en && cap1_hit |=> wp_r == $past(cap1_val);
    endproperty
    a_cap1_pair: assert property (p_cap1_pair) else $error("shared pair not loaded");
endmodule
`default_nettype wire

// ---- tb/pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    input wire logic clk,
    output logic shared_pin,
    output logic wide_pin,
    output logic cap_one_pin,
    output logic cap_two_pin
);
    // ****************************************
    // Pin levels
    // ****************************************
    // Clock pins rest high, so one pulse gives exactly one falling edge
    logic [3:0] act = 4'h0;
    assign shared_pin = ~act[0];
    assign wide_pin = ~act[1];
    assign cap_one_pin = act[2];
    assign cap_two_pin = act[3];

    // ****************************************
    // Pulse train
    // ****************************************
    // Four cycles each side, slower than the synchroniser needs
    task automatic pulse(input logic [3:0] m, input int n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge clk);
            act <= m;
            repeat (4) @(posedge clk);
            act <= 4'h0;
        end
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ---- tb/timers_and_input_capture_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module timers_and_input_capture_tb;
    // ****************************************
    // Signals
    // ****************************************
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, lresp;
    logic [31:0] rdata, lrd;
    logic [7:0] first_count, second_count, mx;
    wire logic p_sh, p_wd, p_c1, p_c2;
    int failures = 0;
    int cmp_count = 0;

    timer_capture timer_capture_inst (
        .CLK(clk), .RST_B(rst_b), .CE(ce),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .SHARED_CLK_PIN(p_sh), .WIDE_CLK_PIN(p_wd),
        .CAP_ONE_PIN(p_c1), .CAP_TWO_PIN(p_c2), .IRQ(irq),
        .FIRST_COUNT(first_count), .SECOND_COUNT(second_count)
    );

    pin_model pin_model_inst (
        .clk(clk), .shared_pin(p_sh), .wide_pin(p_wd),
        .cap_one_pin(p_c1), .cap_two_pin(p_c2)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    // ****************************************
    // Common tasks
    // ****************************************
    task automatic finish_test();
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Address and data offered together; each dropped once its ready is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        lresp = bresp;
        if (n >= 50) begin
            failures++;
            finish_test();
        end
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        lrd = rdata;
        lresp = rresp;
        if (n >= 50) begin
            failures++;
            finish_test();
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rd(8'h58);
        check("ctrl_reset", 32'h0, lrd);
        wr(8'h58, 32'hA5);
        rd(8'h58);
        check("ctrl_rw_a5", 32'hA5, lrd);
        wr(8'h58, 32'h5A);
        rd(8'h58);
        check("ctrl_rw_5a", 32'h5A, lrd);
        rd(8'h00);
        check("unmapped_rresp", 32'h2, lresp);
        check("unmapped_rdata", 32'h0, lrd);
        wr(8'hFC, 32'h1);
        check("unmapped_bresp", 32'h2, lresp);
        wr(8'h58, 32'h0);
    endtask

    // Internal clock, short period, then flag and interrupt handling
    task automatic t_wrap();
        wr(8'h48, 32'h2);
        wr(8'h40, 32'h0);
        wr(8'h70, 32'h1);
        mx = 8'h00;
        repeat (40) begin
            @(posedge clk);
            if (first_count > mx) mx = first_count;
        end
        check("t1_max", 32'h2, mx);
        rd(8'h6C);
        check("t1_flag", 32'h1, lrd & 32'h1);
        check("irq_set", 32'h1, irq);
        wr(8'h48, 32'hFF);
        wr(8'h40, 32'h0);
        wr(8'h70, 32'h0);
        repeat (2) @(posedge clk);
        check("irq_masked", 32'h0, irq);
        wr(8'h6C, 32'h1);
        wr(8'h70, 32'h1);
        repeat (2) @(posedge clk);
        check("irq_cleared", 32'h0, irq);
        rd(8'h6C);
        check("t1_flag_clr", 32'h0, lrd & 32'h1);
    endtask

    task automatic t_ext();
        wr(8'h48, 32'hFF);
        wr(8'h4C, 32'hFF);
        wr(8'h58, 32'h03);
        wr(8'h40, 32'h0);
        wr(8'h44, 32'h0);
        pin_model_inst.pulse(4'h1, 5);
        check("t1_ext", 32'h5, first_count);
        check("t2_ext", 32'h5, second_count);
        rd(8'h44);
        check("t2_reg", 32'h5, lrd);
        ce <= 1'b0;
        pin_model_inst.pulse(4'h1, 2);
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        check("ce_freeze", 32'h5, first_count);
    endtask

    task automatic t_casc();
        wr(8'h58, 32'h09);
        wr(8'h40, 32'hFE);
        wr(8'h44, 32'h0);
        pin_model_inst.pulse(4'h1, 3);
        check("casc_low", 32'h1, first_count);
        check("casc_high", 32'h1, second_count);
    endtask

    task automatic t_wide();
        wr(8'h5C, 32'hFF);
        wr(8'h60, 32'hFF);
        wr(8'h58, 32'h04);
        wr(8'h50, 32'h0);
        wr(8'h54, 32'h0);
        pin_model_inst.pulse(4'h3, 3);
        rd(8'h50);
        check("wide_low", 32'h3, lrd);
        rd(8'h54);
        check("wide_high", 32'h0, lrd);
    endtask

    // Both channels in the same mode; wide timer held still as time base
    task automatic t_cap();
        wr(8'h74, 32'h1);
        for (int m = 0; m < 4; m++) begin
            wr(8'h58, 32'h04 | (m << 6) | (m << 4));
            wr(8'h50, 32'h20 + m);
            wr(8'h54, 32'h34);
            wr(8'h6C, 32'h18);
            if (m >= 2) begin
                pin_model_inst.pulse(4'hC, (m == 2) ? 3 : 15);
                rd(8'h6C);
                check("cap_early", 32'h0, lrd & 32'h18);
            end
            pin_model_inst.pulse(4'hC, 1);
            rd(8'h6C);
            check("cap_hit", 32'h18, lrd & 32'h18);
            rd(8'h64);
            check("cap2_low", 32'h20 + m, lrd);
            rd(8'h68);
            check("cap2_high", 32'h34, lrd);
            rd(8'h5C);
            check("cap1_low", 32'h20 + m, lrd);
            rd(8'h60);
            check("cap1_high", 32'h34, lrd);
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_wrap();
        t_ext();
        t_casc();
        t_wide();
        t_cap();
        finish_test();
    end
endmodule
`default_nettype wire
